// file: common/cskd_pkg.sv
// constants, types and carriers for the count-and-skip decode block
// assumes one core clock with four phase ticks per instruction cycle
package cskd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // instruction word layout
  localparam int unsigned IW_W       = 16;
  localparam int unsigned OPC_MSB    = 15;
  localparam int unsigned OPC_LSB    = 10;
  localparam int unsigned DEST_BIT   = 9;
  localparam int unsigned BANK_BIT   = 8;
  localparam int unsigned FOP_MSB    = 7;
  localparam int unsigned FOP_LSB    = 0;

  localparam logic [5:0] OPC_DEC_SZ  = 6'h0B;
  localparam logic [5:0] OPC_INC_SZ  = 6'h0F;
  localparam logic [5:0] OPC_DEC_SNZ = 6'h13;
  localparam logic [5:0] OPC_INC_SNZ = 6'h12;

  ////////////////////////////////////////////////////////////////////////
  // addressing
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned BANK_W       = 4;
  localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT    = 8'h60;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hF;
  localparam logic        DEST_ACC     = 1'b0;
  localparam logic        BANK_ACCESS  = 1'b0;
  localparam logic [7:0]  ONE          = 8'h01;
  localparam logic [7:0]  ZERO         = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // phases, slots, operations
  typedef enum logic [1:0]
  {
    CSKD_Q1 = 2'b00,
    CSKD_Q2 = 2'b01,
    CSKD_Q3 = 2'b11,
    CSKD_Q4 = 2'b10
  } cskd_phase_t;

  typedef enum logic [1:0]
  {
    CSKD_EXEC  = 2'b00,
    CSKD_IDLE1 = 2'b01,
    CSKD_IDLE2 = 2'b11
  } cskd_slot_t;

  typedef enum logic [2:0]
  {
    CSKD_OP_NONE    = 3'h0,
    CSKD_OP_DEC_SZ  = 3'h1,
    CSKD_OP_INC_SZ  = 3'h2,
    CSKD_OP_DEC_SNZ = 3'h3,
    CSKD_OP_INC_SNZ = 3'h4
  } cskd_op_t;

  ////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed
  {
    logic [IW_W-1:0] word;
    logic            two_word;
  } cskd_fetch_t;

  typedef struct packed
  {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } cskd_file_t;

endpackage

// file: dv/cskd_file_model.sv
// file register model on the far side of the decode core
// answers a read within the read phase; writes land on the strobe edge
`timescale 1ns/10ps
module cskd_file_model
  import cskd_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire cskd_file_t i_file,
  output logic [7:0]      o_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last;
  initial
  begin
    last = 8'h00;
    for (int a = 0; a < 4096; a++)
      mem[a] = a[1] ? a[7:0] : (a[0] ? 8'hFF : 8'h01);
  end
  // unread bus shows the inverse of the last value, never a stale copy
  assign o_rdata = i_file.rd ? mem[i_file.addr] : ~last;
  always @(posedge i_ref_clk)
  begin
    if (i_file.rd) last <= mem[i_file.addr];
    if (i_file.wr) mem[i_file.addr] <= i_file.wdata;
  end
endmodule

// file: dv/cskd_monitor.sv
// assertion checker for the count-and-skip decode core
// sees only the core's ports; bound to every core instance below
`timescale 1ns/10ps
module cskd_monitor
  import cskd_pkg::*;
(
  // clock, reset and inputs
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire cskd_fetch_t       i_fetch,
  input wire logic              i_ext_en,
  input wire logic [BANK_W-1:0] i_bank_ptr,
  input wire logic [ADDR_W-1:0] i_index_base,
  // outputs
  input wire cskd_file_t        o_file,
  input wire logic              o_acc_wr,
  input wire logic              o_flags_wr,
  input wire cskd_phase_t       o_phase,
  input wire logic              o_discard,
  input wire logic              o_idle
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire [7:0] fop = i_fetch.word[FOP_MSB:FOP_LSB];
  wire ok = i_fetch.word[OPC_MSB:OPC_LSB] inside
    {OPC_DEC_SZ, OPC_INC_SZ, OPC_DEC_SNZ, OPC_INC_SNZ};
  // a thrown-away prefetch also sits in a taking phase: discard escapes it
  wire tk = o_phase == CSKD_Q1 && !o_idle;
  wire tko = tk && ok;
  //////////////////////////////////////////////////////////////////////////
  property p_flags; !o_flags_wr; endproperty
  a_flags:
    assert property (p_flags) else $error("flags written");
  property p_take; tko |=> o_file.rd || o_discard; endproperty
  a_take:
    assert property (p_take) else $error("no read");
  property p_ign; tk && !ok |=> !o_file.rd; endproperty
  a_ign:
    assert property (p_ign) else $error("foreign word read");
  property p_seq; o_file.rd |-> (o_phase == CSKD_Q2) ##2
    ((o_file.wr ^ o_acc_wr) && o_phase == CSKD_Q4); endproperty
  a_seq:
    assert property (p_seq) else $error("phase order");
  property p_dest; tko |=> o_discard or
    (##2 o_file.wr == $past(i_fetch.word[DEST_BIT], 3)); endproperty
  a_dest:
    assert property (p_dest) else $error("destination");
  property p_bank; tko && i_fetch.word[BANK_BIT] |=> o_discard ||
    o_file.addr == {$past(i_bank_ptr), $past(fop)}; endproperty
  a_bank:
    assert property (p_bank) else $error("bank address");
  property p_idx; tko && !i_fetch.word[BANK_BIT] && i_ext_en &&
    fop <= IDX_LIMIT |=> o_discard ||
    o_file.addr == $past(i_index_base) + {4'h0, $past(fop)}; endproperty
  a_idx:
    assert property (p_idx) else $error("indexed address");
  property p_idle; o_discard |-> o_idle [*3]; endproperty
  a_idle:
    assert property (p_idle) else $error("idle slot");
  property p_two; o_discard ##2 i_fetch.two_word |-> ##4 o_idle; endproperty
  a_two:
    assert property (p_two) else $error("second idle missing");
  property p_one; o_discard ##2 !i_fetch.two_word |-> ##4 !o_idle;
  endproperty
  a_one:
    assert property (p_one) else $error("idle too long");
  c_two: cover property (o_discard ##2 i_fetch.two_word);
  c_acc: cover property (o_acc_wr);
  c_idx: cover property (tko && i_ext_en && fop <= IDX_LIMIT);
endmodule
bind cskd_core cskd_monitor u_mon (.i_ref_clk, .i_rst_n, .i_fetch,
  .i_ext_en, .i_bank_ptr, .i_index_base, .o_file, .o_acc_wr,
  .o_flags_wr, .o_phase, .o_discard, .o_idle);

// file: dv/cskd_tb.sv
// self-checking bench for the count-and-skip decode core
// drives a fetch word in each taking phase; file model on the far side
`timescale 1ns/10ps
module testbench
  import cskd_pkg::*;
;
  typedef struct packed
  {logic d; logic s; logic [ADDR_W-1:0] a; logic [7:0] v;} cskd_note_t;
  logic              i_ref_clk, i_rst_n, i_ext_en, o_acc_wr, o_flags_wr;
  logic              o_discard, o_idle, exp_sk, o_claimed, exp_cl;
  cskd_fetch_t       i_fetch;
  cskd_file_t        o_file;
  cskd_phase_t       o_phase;
  logic [BANK_W-1:0] i_bank_ptr;
  logic [ADDR_W-1:0] i_index_base;
  logic [7:0]        i_file_rdata, o_acc_wdata;
  logic [7:0]        sh [4096];
  logic [5:0]        ops [5];
  logic [31:0]       seed;
  cskd_note_t        q [$];
  cskd_note_t        nt;
  int                n_fail, n_compared, wait_n;
  cskd_core uut (.i_ref_clk, .i_rst_n, .i_fetch, .i_ext_en, .i_bank_ptr,
    .i_index_base, .i_file_rdata, .o_file, .o_acc_wr, .o_acc_wdata,
    .o_flags_wr, .o_phase, .o_claimed, .o_discard, .o_idle);
  cskd_file_model u_file (.i_ref_clk, .i_file(o_file), .o_rdata(i_file_rdata));
  //////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [11:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // random word each Q1 phase; words landing in idle slots are dropped,
  // since o_idle still stands in the Q1 phase of the next taking cycle
  task run(input int n, input logic ext);
    logic [31:0] r;
    logic [7:0]  f, v;
    logic [11:0] ad;
    int          ix;
    int          drop;
    drop = 0;
    // tail of foreign one-word fetches lets the last results drain
    for (int k = 0; k < n + 20; k++)
    begin
      if (o_phase === CSKD_Q1)
      begin
        r = $random(seed);
        if (k >= n)
          r[5:0] = 6'h04;
        ix = r[2:0] % 5;
        f = r[15:8];
        i_fetch = '{{ops[ix], r[3], r[4], f}, r[5]};
        i_ext_en = ext;
        i_bank_ptr = r[19:16];
        i_index_base = r[31:20];
        exp_cl = (drop != 0) || (ix < 4);
        if (drop == 1)
          drop = r[5] ? 2 : 0; // two-word victim costs a second idle
        else if (drop == 2)
          drop = 0;
        else if (ix < 4)
        begin
          ad = r[4] ? {r[19:16], f} : (ext && f <= IDX_LIMIT) ?
            r[31:20] + {4'h0, f} :
            {(f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, f};
          v = ix[0] ? sh[ad] + ONE : sh[ad] - ONE;
          drop = ((ix < 2) ? (v == ZERO) : (v != ZERO)) ? 1 : 0;
          if (r[3]) sh[ad] = v;
          q.push_back('{r[3], drop != 0, ad, v});
        end
      end
      @(posedge i_ref_clk);
      #1;
    end
    check("pending", q.size(), 0);
    $display("test with extended set %0d done", ext);
  endtask
  // results compared against the oldest note; skip seen two cycles later
  always @(negedge i_ref_clk)
  begin
    if (i_rst_n === 1'b1)
    begin
      if (wait_n == 1) check("discard", o_discard, exp_sk);
      if (wait_n > 0) wait_n--;
      if (o_phase === CSKD_Q2) check("claimed", o_claimed, exp_cl);
      if (o_file.rd === 1'b1) check("addr", o_file.addr, q[0].a);
      if ((o_file.wr | o_acc_wr) === 1'b1)
      begin
        nt = q.pop_front();
        check("dest", o_file.wr, nt.d);
        check("value", nt.d ? o_file.wdata : o_acc_wdata, nt.v);
        exp_sk = nt.s;
        wait_n = 2;
      end
    end
  end
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    repeat (4000) @(posedge i_ref_clk);
    n_fail++;
    conclude();
  end
  initial
  begin
    ops = '{OPC_DEC_SZ, OPC_INC_SZ, OPC_DEC_SNZ, OPC_INC_SNZ, 6'h00};
    seed = 32'h98A8FEB1;
    {n_fail, n_compared, wait_n} = '0;
    {i_rst_n, i_ext_en, i_bank_ptr, i_index_base, exp_sk, exp_cl} = '0;
    i_fetch = '0;
    for (int a = 0; a < 4096; a++)
      sh[a] = a[1] ? a[7:0] : (a[0] ? 8'hFF : 8'h01);
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    run(700, 1'b0);
    run(700, 1'b1);
    conclude();
  end
endmodule

// file: logic/cskd_core.sv
// decode and execute of the four count-and-skip file instructions
// assumes fetch word and file read data come from logic on i_ref_clk;
// file read data is valid in the same phase in which o_file.rd is high
`timescale 1ns/10ps

// What this block does
// - decrement file, skip next if zero
// - increment file, skip next if zero
// - decrement file, skip next if nonzero
// - increment file, skip next if nonzero
// - dest bit picks accumulator or file
// - skip discards prefetch, runs idle slot
// - one word; cycles 1, 2, or 3
// - extended mode, offset up to 95 indexed
// - decode, read, compute, write per phase
// - bank bit picks access or pointer bank
module cskd_core
  import cskd_pkg::*;
#(
  parameter logic [7:0] ACCESS_SPLIT = ACC_SPLIT
)
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  // fetch path
  input  wire cskd_fetch_t       i_fetch,
  // addressing context
  input  wire logic              i_ext_en,
  input  wire logic [BANK_W-1:0] i_bank_ptr,
  input  wire logic [ADDR_W-1:0] i_index_base,
  // file registers
  input  wire logic [7:0]        i_file_rdata,
  output cskd_file_t             o_file,
  // accumulator and status
  output logic                   o_acc_wr,
  output logic [7:0]             o_acc_wdata,
  output logic                   o_flags_wr,
  // sequencing
  output cskd_phase_t            o_phase,
  output logic                   o_claimed,
  output logic                   o_discard,
  output logic                   o_idle
);

  // refused at elaboration: a split past the window leaves a gap
  if (ACCESS_SPLIT > IDX_LIMIT + ONE)
  begin
    $error("ACCESS_SPLIT above indexed window end");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic cskd_op_t decode_op(input logic [5:0] opc);
    cskd_op_t r;
    r = CSKD_OP_NONE;
    case (opc)
      OPC_DEC_SZ:  r = CSKD_OP_DEC_SZ;
      OPC_INC_SZ:  r = CSKD_OP_INC_SZ;
      OPC_DEC_SNZ: r = CSKD_OP_DEC_SNZ;
      OPC_INC_SNZ: r = CSKD_OP_INC_SNZ;
      default:     r = CSKD_OP_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] eff_addr(
    input logic              bank_sel,
    input logic [7:0]        fop,
    input logic              ext,
    input logic [BANK_W-1:0] bptr,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] r;
    r = {bptr, fop};
    if (bank_sel == BANK_ACCESS)
    begin
      if (ext && fop <= IDX_LIMIT)
        r = base + {{(ADDR_W-8){1'b0}}, fop};
      else if (fop < ACCESS_SPLIT)
        r = {ACC_LO_BANK, fop};
      else
        r = {ACC_HI_BANK, fop};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  cskd_phase_t       phase_reg,  phase_next;
  cskd_slot_t        slot_reg,   slot_next;
  cskd_op_t          op_reg,     op_next;
  logic              dest_reg,   dest_next;
  logic [ADDR_W-1:0] addr_reg,   addr_next;
  logic [7:0]        res_reg,    res_next;
  logic              skip_reg,   skip_next;
  cskd_file_t        file_reg,   file_next;
  logic              accw_reg,   accw_next;
  logic [7:0]        accd_reg,   accd_next;
  logic              disc_reg,   disc_next;
  logic              idle_reg,   idle_next;
  logic              claim_reg,  claim_next;

  logic              is_dec;
  logic              skip_on_zero;
  logic [7:0]        sum;

  always_comb
  begin
    is_dec       = (op_reg == CSKD_OP_DEC_SZ) || (op_reg == CSKD_OP_DEC_SNZ);
    skip_on_zero = (op_reg == CSKD_OP_DEC_SZ) || (op_reg == CSKD_OP_INC_SZ);
    sum          = is_dec ? i_file_rdata - ONE : i_file_rdata + ONE;

    phase_next = phase_reg;
    slot_next  = slot_reg;
    op_next    = op_reg;
    dest_next  = dest_reg;
    addr_next  = addr_reg;
    res_next   = res_reg;
    skip_next  = skip_reg;
    file_next  = file_reg;
    accw_next  = 1'b0;
    accd_next  = accd_reg;
    disc_next  = 1'b0;
    idle_next  = idle_reg;
    claim_next = claim_reg;
    file_next.rd = 1'b0;
    file_next.wr = 1'b0;

    case (phase_reg)
      CSKD_Q1:
      begin
        phase_next = CSKD_Q2;
        // file read request goes out for Q2
        if (slot_reg == CSKD_EXEC)
        begin
          op_next    = decode_op(i_fetch.word[OPC_MSB:OPC_LSB]);
          dest_next  = i_fetch.word[DEST_BIT];
          addr_next  = eff_addr(i_fetch.word[BANK_BIT],
                                i_fetch.word[FOP_MSB:FOP_LSB],
                                i_ext_en, i_bank_ptr, i_index_base);
          claim_next = decode_op(i_fetch.word[OPC_MSB:OPC_LSB])
                       != CSKD_OP_NONE;
          idle_next  = 1'b0;
          file_next.rd   = claim_next;
          file_next.addr = addr_next;
        end
        else
        begin
          // whole slot does nothing; prefetch is thrown away
          op_next    = CSKD_OP_NONE;
          claim_next = 1'b1;
          idle_next  = 1'b1;
          disc_next  = (slot_reg == CSKD_IDLE1);
        end
      end
      CSKD_Q2:
      begin
        phase_next = CSKD_Q3;
        if (op_reg != CSKD_OP_NONE)
        begin
          res_next  = sum;
          skip_next = skip_on_zero ? (sum == ZERO)
                                   : (sum != ZERO);
        end
        else
          skip_next = 1'b0;
      end
      CSKD_Q3:
      begin
        phase_next = CSKD_Q4;
        if (op_reg != CSKD_OP_NONE)
        begin
          if (dest_reg == DEST_ACC)
          begin
            accw_next = 1'b1;
            accd_next = res_reg;
          end
          else
          begin
            file_next.wr    = 1'b1;
            file_next.addr  = addr_reg;
            file_next.wdata = res_reg;
          end
        end
      end
      CSKD_Q4:
      begin
        phase_next = CSKD_Q1;
        // next cycle: one idle, second idle decided from the
        // discarded word's length at Q4 of the first idle cycle
        case (slot_reg)
          CSKD_EXEC:  slot_next = skip_reg ? CSKD_IDLE1 : CSKD_EXEC;
          CSKD_IDLE1: slot_next = i_fetch.two_word ? CSKD_IDLE2
                                                   : CSKD_EXEC;
          CSKD_IDLE2: slot_next = CSKD_EXEC;
          default:    slot_next = CSKD_EXEC;
        endcase
        if (slot_reg != CSKD_EXEC)
          skip_next = 1'b0;
      end
      default:
        phase_next = CSKD_Q1;
    endcase
  end

  // length of the discarded word must be known at Q4 of the first idle
  // cycle; fetch path holds i_fetch over the whole instruction cycle

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      phase_reg <= CSKD_Q1;
      slot_reg  <= CSKD_EXEC;
      op_reg    <= CSKD_OP_NONE;
      dest_reg  <= 1'b0;
      addr_reg  <= '0;
      res_reg   <= ZERO;
      skip_reg  <= 1'b0;
      file_reg  <= '0;
      accw_reg  <= 1'b0;
      accd_reg  <= ZERO;
      disc_reg  <= 1'b0;
      idle_reg  <= 1'b0;
      claim_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      slot_reg  <= slot_next;
      op_reg    <= op_next;
      dest_reg  <= dest_next;
      addr_reg  <= addr_next;
      res_reg   <= res_next;
      skip_reg  <= skip_next;
      file_reg  <= file_next;
      accw_reg  <= accw_next;
      accd_reg  <= accd_next;
      disc_reg  <= disc_next;
      idle_reg  <= idle_next;
      claim_reg <= claim_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_file      = file_reg;
  assign o_acc_wr    = accw_reg;
  assign o_acc_wdata = accd_reg;
  assign o_flags_wr  = 1'b0 & claim_reg;
  assign o_phase     = phase_reg;
  assign o_claimed   = claim_reg;
  assign o_discard   = disc_reg;
  assign o_idle      = idle_reg;

endmodule
